// [src/fapcd_params.svh]
// Constants for the flash service dispatcher: offsets, codes, selectors and timing.
`ifndef FAPCD_PARAMS_SVH
`define FAPCD_PARAMS_SVH

// ********************************
// Wishbone register map
// ********************************
`define FAPCD_OFF_FUNC 4'h0
`define FAPCD_OFF_AHI 4'h1
`define FAPCD_OFF_ALO 4'h2
`define FAPCD_OFF_DATA 4'h3
`define FAPCD_OFF_ENTRY 4'h4
`define FAPCD_OFF_STAT 4'h5
`define FAPCD_OFF_CFG 4'h6
`define FAPCD_ENTRY_ADDR 16'hFFF0

// ********************************
// Function codes and selectors
// ********************************
`define FAPCD_FN_ID 7'h00
`define FAPCD_FN_BLKERASE 7'h01
`define FAPCD_FN_PROG 7'h02
`define FAPCD_FN_READ 7'h03
`define FAPCD_FN_CFGERASE 7'h04
`define FAPCD_FN_SECPROG 7'h05
`define FAPCD_FN_CFGPROG 7'h06
`define FAPCD_FN_CFGREAD 7'h07
`define FAPCD_FN_PGERASE 7'h08
`define FAPCD_WD_BIT 7
`define FAPCD_SEL_0 8'h00
`define FAPCD_SEL_1 8'h01
`define FAPCD_SEL_2 8'h02
`define FAPCD_SEL_3 8'h03
`define FAPCD_SEL_VER 8'h80
`define FAPCD_BLK_1 8'h20
`define FAPCD_BLK_2 8'h40
`define FAPCD_BLK_3 8'h80
`define FAPCD_BLK_4 8'hC0
`define FAPCD_PASS 8'h00
`define FAPCD_FAIL 8'hFF
`define FAPCD_ERASED 8'hFF
`define FAPCD_MODE6_BIT 7

// ********************************
// Identity values, arbitrary neutral values
// ********************************
`define FAPCD_MAKER_ID 8'h5A
`define FAPCD_DEV_ID1 8'hA1
`define FAPCD_DEV_ID2 8'hA2
`define FAPCD_FW_VER 8'h10

// ********************************
// Geometry and timing
// ********************************
`define FAPCD_MEM_AW 16
`define FAPCD_PAGE_BITS 7
`define FAPCD_PAGE_SIZE 17'd128
`define FAPCD_BLK8K 17'd8192
`define FAPCD_BLK16K 17'd16384
`define FAPCD_CLK_MHZ 100
`define FAPCD_PROG_NS 1000
`define FAPCD_PROG_CYC (`FAPCD_PROG_NS * `FAPCD_CLK_MHZ / 1000)

`endif

// [src/fapcd_pkg.sv]
// Types shared by the flash service dispatcher files.
package fapcd_pkg;

    typedef struct packed {
        logic [7:0] funcCode;
        logic [7:0] addrHigh;
        logic [7:0] addrLowSel;
        logic [7:0] dataIn;
    } fapcd_req_t;

    typedef struct packed {
        logic busy;
        logic done;
        logic [7:0] result;
    } fapcd_rsp_t;

    typedef struct packed {
        logic [2:0] secBits;
        logic statusBit;
        logic [7:0] bootVector;
        logic sixClock;
    } fapcd_cfg_t;

    typedef enum logic [1:0] {
        FAPCD_MOP_NONE,
        FAPCD_MOP_WRITE,
        FAPCD_MOP_ERASE
    } fapcd_mop_t;

endpackage

// [src/fapcd_wb_slave.sv]
// Wishbone classic slave holding the call parameters and the entry trigger.
`timescale 1ns/1ps
`include "fapcd_params.svh"
module fapcd_wb_slave (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clockEn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [7:0] wb_dat_i,
    input wire logic wb_sel_i,
    output logic [7:0] wb_dat_o,
    output logic wb_ack_o,
    output fapcd_pkg::fapcd_req_t req,
    output logic callStart,
    input wire fapcd_pkg::fapcd_rsp_t rsp,
    input wire fapcd_pkg::fapcd_cfg_t cfg
);
    import fapcd_pkg::*;

    logic ackQ;
    logic [7:0] datQ;
    fapcd_req_t reqQ;
    logic startQ;
    wire access = wb_cyc_i && wb_stb_i && !ackQ;
    wire wrEn = access && wb_we_i && wb_sel_i && !rsp.busy;
    wire [7:0] statusWord = {6'h00, rsp.done, rsp.busy};
    wire [7:0] cfgWord = {cfg.sixClock, 3'h0, cfg.statusBit, cfg.secBits};
    wire [7:0] readMux =
        (wb_adr_i == `FAPCD_OFF_FUNC) ? reqQ.funcCode :
        (wb_adr_i == `FAPCD_OFF_AHI) ? reqQ.addrHigh :
        (wb_adr_i == `FAPCD_OFF_ALO) ? reqQ.addrLowSel :
        (wb_adr_i == `FAPCD_OFF_DATA) ? (rsp.done ? rsp.result : reqQ.dataIn) :
        (wb_adr_i == `FAPCD_OFF_STAT) ? statusWord :
        (wb_adr_i == `FAPCD_OFF_CFG) ? cfgWord : 8'h00;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ackQ <= 1'b0;
            datQ <= 8'h00;
            reqQ <= '0;
            startQ <= 1'b0;
        end else if (clockEn) begin
            ackQ <= access;
            datQ <= readMux;
            startQ <= wrEn && (wb_adr_i == `FAPCD_OFF_ENTRY);
            if (wrEn && wb_adr_i == `FAPCD_OFF_FUNC) reqQ.funcCode <= wb_dat_i;
            if (wrEn && wb_adr_i == `FAPCD_OFF_AHI) reqQ.addrHigh <= wb_dat_i;
            if (wrEn && wb_adr_i == `FAPCD_OFF_ALO) reqQ.addrLowSel <= wb_dat_i;
            if (wrEn && wb_adr_i == `FAPCD_OFF_DATA) reqQ.dataIn <= wb_dat_i;
        end
    end

    assign wb_ack_o = ackQ;
    assign wb_dat_o = datQ;
    assign req = reqQ;
    assign callStart = startQ;
endmodule

// [src/fapcd_flash_array.sv]
// Flip-flop model of the 64 kB code store with byte write and range erase.
`timescale 1ns/1ps
`include "fapcd_params.svh"
module fapcd_flash_array (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clockEn,
    input wire fapcd_pkg::fapcd_mop_t memOp,
    input wire logic [15:0] memAddr,
    input wire logic [16:0] eraseEnd,
    input wire logic [7:0] memWData,
    output logic [7:0] memRData
);
    import fapcd_pkg::*;

    localparam int Depth = 1 << `FAPCD_MEM_AW;
    logic [7:0] mem [Depth];

    // Erase covers [memAddr, eraseEnd) in one cycle; the sequencer models the wall time.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            for (int i = 0; i < Depth; i++) mem[i] <= `FAPCD_ERASED;
        end else if (clockEn) begin
            if (memOp == FAPCD_MOP_WRITE) mem[memAddr] <= memWData;
            if (memOp == FAPCD_MOP_ERASE) begin
                for (int i = 0; i < Depth; i++) begin
                    if (i >= int'(memAddr) && i < int'(eraseEnd)) mem[i] <= `FAPCD_ERASED;
                end
            end
        end
    end

    assign memRData = mem[memAddr];
endmodule

// [src/fapcd_dispatch.sv]
// Flash service dispatcher top: entry decode, operation sequencing and result return.
// ********************************
// Functional notes
// - One entry point starts every service; only the parameter values choose the operation.
// - Code 00H reads identity with address-high 00H; any code with bit 7 set also feeds the watchdog.
// - Identity selectors 00H, 01H, 02H return maker, first and second device codes.
// - Identity selector 03H returns the clock mode in bit 7, high for six-clock mode.
// - Identity selector 80H returns the resident programming firmware version.
// - Code 01H erases one code block by selector and returns 00 on pass, nonzero on fail.
// - Block selectors 00H, 20H, 40H, 80H, C0H map to 0-8, 8-16, 16-32, 32-48, 48-64 kB.
// - Code 02H programs the data byte at the high/low address and returns pass or fail.
// - Code 03H returns the user code byte at the high/low address.
// - Code 04H erases status bit and boot vector, ignoring the address, and returns pass/fail.
// - Code 05H programs security bit 1, 2 or 3 for selector 00H, 01H, 02H, with pass/fail.
// - Code 06H programs the status bit, boot vector from data, or clock-mode bit by selector.
// - Code 07H returns the security bits, status bit or boot vector by selector.
// - Code 08H erases the page at the high/low address and returns pass or fail.
// - A page erase clears one 128-byte page aligned to the given address.
// ********************************
`timescale 1ns/1ps
`include "fapcd_params.svh"
module fapcd_dispatch (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clockEn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [7:0] wb_dat_i,
    input wire logic wb_sel_i,
    output logic [7:0] wb_dat_o,
    output logic wb_ack_o,
    output logic watchdogFeed,
    output logic serviceBusy
);
    import fapcd_pkg::*;

    typedef enum logic [1:0] {FAPCD_IDLE, FAPCD_WAIT, FAPCD_FINISH} fapcd_state_t;

    localparam int ProgCyc = (`FAPCD_PROG_CYC < 1) ? 1 : `FAPCD_PROG_CYC;

    fapcd_req_t req;
    fapcd_rsp_t rsp;
    fapcd_cfg_t cfgQ;
    fapcd_cfg_t cfgD;
    logic callStart;
    fapcd_state_t stateQ;
    logic [7:0] resultQ;
    logic doneQ;
    logic wdQ;
    logic [15:0] waitQ;
    fapcd_mop_t memOp;
    logic [15:0] memAddr;
    logic [16:0] eraseEnd;
    logic [7:0] memRData;

    // ********************************
    // Request decoding
    // ********************************
    function automatic logic [7:0] sel_pick(input logic [7:0] sel, input logic [7:0] v0,
                                            input logic [7:0] v1, input logic [7:0] v2,
                                            input logic ok2);
        if (sel == `FAPCD_SEL_0) return v0;
        if (sel == `FAPCD_SEL_1) return v1;
        if (sel == `FAPCD_SEL_2 && ok2) return v2;
        return `FAPCD_FAIL;
    endfunction

    wire [6:0] fn = req.funcCode[6:0];
    wire [7:0] sel = req.addrLowSel;
    wire [15:0] fullAddr = {req.addrHigh, req.addrLowSel};
    wire isId = fn == `FAPCD_FN_ID;
    wire isBlk = fn == `FAPCD_FN_BLKERASE;
    wire isProg = fn == `FAPCD_FN_PROG;
    wire isRead = fn == `FAPCD_FN_READ;
    wire isCfgErase = fn == `FAPCD_FN_CFGERASE;
    wire isSec = fn == `FAPCD_FN_SECPROG;
    wire isCfgProg = fn == `FAPCD_FN_CFGPROG;
    wire isCfgRead = fn == `FAPCD_FN_CFGREAD;
    wire isPage = fn == `FAPCD_FN_PGERASE;

    // Block selector to start address and length.
    wire blkValid = sel == `FAPCD_SEL_0 || sel == `FAPCD_BLK_1 || sel == `FAPCD_BLK_2 ||
                    sel == `FAPCD_BLK_3 || sel == `FAPCD_BLK_4;
    wire [16:0] blkStart = {1'b0, sel, 8'h00};
    wire [16:0] blkLen = (sel == `FAPCD_SEL_0 || sel == `FAPCD_BLK_1) ?
                         `FAPCD_BLK8K : `FAPCD_BLK16K;
    wire [15:0] pageBase = {fullAddr[15:`FAPCD_PAGE_BITS], {`FAPCD_PAGE_BITS{1'b0}}};

    // Identity value chosen by the low selector; address-high must be zero.
    wire [7:0] clockModeByte = {cfgQ.sixClock, 7'h00};
    wire [7:0] idLow = sel_pick(sel, `FAPCD_MAKER_ID, `FAPCD_DEV_ID1, `FAPCD_DEV_ID2, 1'b1);
    wire [7:0] idValue = (req.addrHigh != `FAPCD_SEL_0) ? `FAPCD_FAIL :
                         (sel == `FAPCD_SEL_3) ? clockModeByte :
                         (sel == `FAPCD_SEL_VER) ? `FAPCD_FW_VER : idLow;
    wire [7:0] cfgReadValue = sel_pick(sel, {5'h00, cfgQ.secBits},
                                       {7'h00, cfgQ.statusBit}, cfgQ.bootVector, 1'b1);
    wire secValid = sel == `FAPCD_SEL_0 || sel == `FAPCD_SEL_1 || sel == `FAPCD_SEL_2;
    wire cfgProgValid = secValid;
    wire knownFn = isId || isBlk || isProg || isRead || isCfgErase || isSec ||
                   isCfgProg || isCfgRead || isPage;

    // Immediate answers finish in one cycle; flash changes run through the timed wait.
    wire timedOp = isProg || isPage || (isBlk && blkValid) || isCfgErase ||
                   (isSec && secValid) || (isCfgProg && cfgProgValid);
    wire [7:0] immResult = isId ? idValue :
                           isRead ? memRData :
                           isCfgRead ? cfgReadValue : `FAPCD_FAIL;

    // Flash port drive: address, range and operation during the final cycle of a timed call.
    wire opFire = stateQ == FAPCD_WAIT && waitQ == 16'h0000;
    assign memAddr = isPage ? pageBase : isBlk ? blkStart[15:0] : fullAddr;
    assign eraseEnd = isPage ? ({1'b0, pageBase} + `FAPCD_PAGE_SIZE) : (blkStart + blkLen);
    assign memOp = !opFire ? FAPCD_MOP_NONE :
                   isProg ? FAPCD_MOP_WRITE :
                   (isPage || isBlk) ? FAPCD_MOP_ERASE : FAPCD_MOP_NONE;

    // Configuration updates; secBits index follows the selector.
    always_comb begin
        cfgD = cfgQ;
        if (opFire && isCfgErase) begin
            cfgD.statusBit = 1'b0;
            cfgD.bootVector = `FAPCD_ERASED;
        end
        if (opFire && isSec) cfgD.secBits[sel[1:0]] = 1'b1;
        if (opFire && isCfgProg) begin
            if (sel == `FAPCD_SEL_0) cfgD.statusBit = 1'b1;
            if (sel == `FAPCD_SEL_1) cfgD.bootVector = req.dataIn;
            if (sel == `FAPCD_SEL_2) cfgD.sixClock = 1'b1;
        end
    end

    // ********************************
    // Sequencer
    // ********************************
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            stateQ <= FAPCD_IDLE;
            resultQ <= `FAPCD_PASS;
            doneQ <= 1'b0;
            wdQ <= 1'b0;
            waitQ <= 16'h0000;
            cfgQ <= '0;
            cfgQ.bootVector <= `FAPCD_ERASED;
        end else if (clockEn) begin
            wdQ <= callStart && req.funcCode[`FAPCD_WD_BIT];
            cfgQ <= cfgD;
            unique case (stateQ)
                FAPCD_IDLE: begin
                    if (callStart) begin
                        doneQ <= 1'b0;
                        if (knownFn && timedOp) begin
                            waitQ <= 16'(ProgCyc - 1);
                            stateQ <= FAPCD_WAIT;
                        end else begin
                            resultQ <= knownFn ? immResult : `FAPCD_FAIL;
                            stateQ <= FAPCD_FINISH;
                        end
                    end
                end
                FAPCD_WAIT: begin
                    if (waitQ == 16'h0000) begin
                        resultQ <= `FAPCD_PASS;
                        stateQ <= FAPCD_FINISH;
                    end else begin
                        waitQ <= waitQ - 16'h0001;
                    end
                end
                FAPCD_FINISH: begin
                    doneQ <= 1'b1;
                    stateQ <= FAPCD_IDLE;
                end
            endcase
        end
    end

    assign rsp.busy = stateQ != FAPCD_IDLE;
    assign rsp.done = doneQ;
    assign rsp.result = resultQ;

    logic busyQ;
    always_ff @(posedge clock) begin
        if (sys_rst) busyQ <= 1'b0;
        else if (clockEn) busyQ <= (stateQ != FAPCD_IDLE) || callStart;
    end
    assign serviceBusy = busyQ;
    assign watchdogFeed = wdQ;

    fapcd_wb_slave u_slave (
        .clock(clock),
        .sys_rst(sys_rst),
        .clockEn(clockEn),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .req(req),
        .callStart(callStart),
        .rsp(rsp),
        .cfg(cfgQ)
    );

    fapcd_flash_array u_flash (
        .clock(clock),
        .sys_rst(sys_rst),
        .clockEn(clockEn),
        .memOp(memOp),
        .memAddr(memAddr),
        .eraseEnd(eraseEnd),
        .memWData(req.dataIn),
        .memRData(memRData)
    );

    // ********************************
    // Checks
    // ********************************
    a_wd_feed_bit: assert property (@(posedge clock) disable iff (sys_rst)
        clockEn && callStart && req.funcCode[`FAPCD_WD_BIT] |=> watchdogFeed)
        else $error("Watchdog feed missing after call with bit 7 set.");
    a_wd_no_feed: assert property (@(posedge clock) disable iff (sys_rst)
        clockEn && callStart && !req.funcCode[`FAPCD_WD_BIT] |=> !watchdogFeed)
        else $error("Watchdog fed without bit 7.");
    a_unknown_fails: assert property (@(posedge clock) disable iff (sys_rst)
        clockEn && stateQ == FAPCD_IDLE && callStart && !knownFn |=> resultQ == `FAPCD_FAIL)
        else $error("Undefined function code did not fail.");
    a_unknown_no_op: assert property (@(posedge clock) disable iff (sys_rst)
        !knownFn |-> memOp == FAPCD_MOP_NONE)
        else $error("Undefined function code touched flash.");
    a_id_maker: assert property (@(posedge clock) disable iff (sys_rst)
        clockEn && stateQ == FAPCD_IDLE && callStart && isId && req.addrHigh == 8'h00 &&
        sel == `FAPCD_SEL_0 |=> resultQ == `FAPCD_MAKER_ID)
        else $error("Maker code not returned.");
    a_id_clock_mode: assert property (@(posedge clock) disable iff (sys_rst)
        clockEn && stateQ == FAPCD_IDLE && callStart && isId && req.addrHigh == 8'h00 &&
        sel == `FAPCD_SEL_3 |=> resultQ[`FAPCD_MODE6_BIT] == $past(cfgQ.sixClock))
        else $error("Clock mode bit not returned in bit 7.");
    a_page_aligned: assert property (@(posedge clock) disable iff (sys_rst)
        memOp == FAPCD_MOP_ERASE && isPage |->
        memAddr[`FAPCD_PAGE_BITS-1:0] == '0 && eraseEnd == {1'b0, memAddr} + `FAPCD_PAGE_SIZE)
        else $error("Page erase not 128-byte aligned.");
    a_blk_range: assert property (@(posedge clock) disable iff (sys_rst)
        memOp == FAPCD_MOP_ERASE && isBlk && sel == `FAPCD_BLK_3 |->
        memAddr == 16'h8000 && eraseEnd == 17'h0C000)
        else $error("Block 3 range wrong.");
    a_timed_pass: assert property (@(posedge clock) disable iff (sys_rst)
        opFire && clockEn |=> stateQ == FAPCD_FINISH && resultQ == `FAPCD_PASS)
        else $error("Timed operation did not report pass.");
    a_boot_prog: assert property (@(posedge clock) disable iff (sys_rst)
        opFire && clockEn && isCfgProg && sel == `FAPCD_SEL_1 |=> cfgQ.bootVector == $past(req.dataIn))
        else $error("Boot vector not programmed from data byte.");

    // Immediate answers are judged one cycle after the entry strobe leaves idle.
    a_idle_holds: assert property (@(posedge clock) disable iff (sys_rst)
        clockEn && stateQ == FAPCD_IDLE && !callStart |=> stateQ == FAPCD_IDLE)
        else $error("Sequencer left idle without an entry call.");
    a_id_dev1: assert property (@(posedge clock) disable iff (sys_rst)
        clockEn && stateQ == FAPCD_IDLE && callStart && isId && req.addrHigh == 8'h00 &&
        sel == `FAPCD_SEL_1 |=> resultQ == `FAPCD_DEV_ID1)
        else $error("First device code not returned.");
    a_id_dev2: assert property (@(posedge clock) disable iff (sys_rst)
        clockEn && stateQ == FAPCD_IDLE && callStart && isId && req.addrHigh == 8'h00 &&
        sel == `FAPCD_SEL_2 |=> resultQ == `FAPCD_DEV_ID2)
        else $error("Second device code not returned.");
    a_id_version: assert property (@(posedge clock) disable iff (sys_rst)
        clockEn && stateQ == FAPCD_IDLE && callStart && isId && req.addrHigh == 8'h00 &&
        sel == `FAPCD_SEL_VER |=> resultQ == `FAPCD_FW_VER)
        else $error("Firmware version not returned.");
    a_blk_bad_sel: assert property (@(posedge clock) disable iff (sys_rst)
        clockEn && stateQ == FAPCD_IDLE && callStart && isBlk && !blkValid |=>
        stateQ == FAPCD_FINISH && resultQ == `FAPCD_FAIL)
        else $error("Bad block selector did not fail at once.");
    a_prog_write: assert property (@(posedge clock) disable iff (sys_rst)
        opFire && isProg |-> memOp == FAPCD_MOP_WRITE && memAddr == fullAddr)
        else $error("Program call did not write the addressed byte.");
    a_read_data: assert property (@(posedge clock) disable iff (sys_rst)
        clockEn && stateQ == FAPCD_IDLE && callStart && isRead |=> resultQ == $past(memRData))
        else $error("Read call did not return the stored byte.");
    a_cfg_erase: assert property (@(posedge clock) disable iff (sys_rst)
        opFire && clockEn && isCfgErase |=> !cfgQ.statusBit && cfgQ.bootVector == `FAPCD_ERASED)
        else $error("Status bit and boot vector not erased.");
    a_sec_prog: assert property (@(posedge clock) disable iff (sys_rst)
        opFire && clockEn && isSec |=> cfgQ.secBits[$past(sel[1:0])] == 1'b1)
        else $error("Selected security bit not programmed.");
    a_status_prog: assert property (@(posedge clock) disable iff (sys_rst)
        opFire && clockEn && isCfgProg && sel == `FAPCD_SEL_0 |=> cfgQ.statusBit)
        else $error("Status bit not programmed.");
    a_six_prog: assert property (@(posedge clock) disable iff (sys_rst)
        opFire && clockEn && isCfgProg && sel == `FAPCD_SEL_2 |=> cfgQ.sixClock)
        else $error("Clock-mode bit not programmed.");
    a_cfg_read: assert property (@(posedge clock) disable iff (sys_rst)
        clockEn && stateQ == FAPCD_IDLE && callStart && isCfgRead &&
        sel == `FAPCD_SEL_2 |=> resultQ == $past(cfgQ.bootVector))
        else $error("Boot vector not read back.");
    a_page_erase_op: assert property (@(posedge clock) disable iff (sys_rst)
        opFire && isPage |-> memOp == FAPCD_MOP_ERASE && memAddr == pageBase)
        else $error("Page erase call did not erase the page.");

    c_prog_call: cover property (@(posedge clock) opFire && isProg);
    c_page_erase: cover property (@(posedge clock) opFire && isPage);
    c_id_read: cover property (@(posedge clock) callStart && isId);
    c_bad_code: cover property (@(posedge clock) callStart && !knownFn);
    c_blk_erase: cover property (@(posedge clock) opFire && isBlk);
endmodule

// [tb/fapcd_app_model.sv]
// Application program model that calls the flash service over Wishbone classic.
`timescale 1ns/1ps
`include "fapcd_params.svh"
module fapcd_app_model (
    input wire logic clock,
    input wire logic wb_ack_i,
    input wire logic [7:0] wb_dat_i,
    output logic wb_cyc_o,
    output logic wb_stb_o,
    output logic wb_we_o,
    output logic [3:0] wb_adr_o,
    output logic [7:0] wb_dat_o,
    output logic wb_sel_o
);
    initial begin
        wb_cyc_o = 1'b0;
        wb_stb_o = 1'b0;
        wb_we_o = 1'b0;
        wb_adr_o = 4'h0;
        wb_dat_o = 8'h00;
        wb_sel_o = 1'b0;
    end

    // The wait has no limit of its own; the bench watchdog cuts a hang short.
    task automatic access(input logic we, input logic [3:0] adr, input logic [7:0] dat,
                          output logic [7:0] rdat);
        @(posedge clock);
        wb_cyc_o <= 1'b1;
        wb_stb_o <= 1'b1;
        wb_we_o <= we;
        wb_adr_o <= adr;
        wb_dat_o <= dat;
        wb_sel_o <= 1'b1;
        @(posedge clock);
        while (wb_ack_i !== 1'b1) @(posedge clock);
        rdat = wb_dat_i;
        wb_cyc_o <= 1'b0;
        wb_stb_o <= 1'b0;
        wb_we_o <= 1'b0;
        wb_sel_o <= 1'b0;
        // Released lines carry the inverse so stale values are never mistaken for live ones.
        wb_adr_o <= ~adr;
        wb_dat_o <= ~dat;
    endtask

    task automatic callService(input logic [7:0] fn, input logic [7:0] ahi,
                               input logic [7:0] alo, input logic [7:0] dat,
                               output logic [7:0] res);
        logic [7:0] stat;
        access(1'b1, `FAPCD_OFF_FUNC, fn, stat);
        access(1'b1, `FAPCD_OFF_AHI, ahi, stat);
        access(1'b1, `FAPCD_OFF_ALO, alo, stat);
        access(1'b1, `FAPCD_OFF_DATA, dat, stat);
        access(1'b1, `FAPCD_OFF_ENTRY, 8'h00, stat);
        stat = 8'h00;
        while (stat[1] !== 1'b1) access(1'b0, `FAPCD_OFF_STAT, 8'h00, stat);
        access(1'b0, `FAPCD_OFF_DATA, 8'h00, res);
    endtask
endmodule

// [tb/test_flash_app_program_call_dispatch.sv]
// Self-checking bench for the flash service dispatcher.
`timescale 1ns/1ps
`include "fapcd_params.svh"
module test_flash_app_program_call_dispatch;
    logic clock;
    logic sys_rst;
    logic clockEn;
    logic wbCyc, wbStb, wbWe, wbSel, wbAck, watchdogFeed, serviceBusy;
    logic [3:0] wbAdr;
    logic [7:0] wbDatW, wbDatR, got, f, h, l, d, e;
    int badCount = 0;
    int testsRun = 0;
    int wdCount = 0;
    // Columns: function, address high, address low or selector, data, expected result.
    logic [39:0] rows [0:46] = '{
        40'h00_00_00_00_5A, 40'h80_00_01_00_A1, 40'h00_00_02_00_A2,
        40'h80_00_03_00_00, 40'h00_00_80_00_10, 40'h00_01_00_00_FF,
        40'h87_00_00_00_00, 40'h07_00_01_00_00, 40'h07_00_02_00_FF,
        40'h05_00_00_00_00, 40'h85_00_01_00_00, 40'h05_00_02_00_00, 40'h05_00_03_00_FF,
        40'h07_00_00_00_07, 40'h86_00_00_00_00, 40'h06_00_01_3C_00,
        40'h07_00_02_00_3C, 40'h06_00_02_00_00, 40'h00_00_03_00_80,
        40'h84_55_AA_00_00, 40'h07_00_02_00_FF,
        40'h02_12_34_A5_00, 40'h83_12_34_00_A5, 40'h02_BF_FF_22_00, 40'h82_C0_00_11_00,
        40'h01_00_C0_00_00, 40'h03_C0_00_00_FF, 40'h03_BF_FF_00_22, 40'h01_00_10_00_FF,
        40'h02_12_80_66_00, 40'h02_12_FF_77_00, 40'h02_13_00_88_00, 40'h88_12_80_00_00,
        40'h03_12_80_00_FF, 40'h03_12_FF_00_FF, 40'h03_13_00_00_88, 40'h03_12_34_00_A5,
        40'h09_12_34_00_FF, 40'h89_12_34_A0_FF, 40'h7F_00_00_00_FF, 40'h03_12_34_00_A5,
        40'h81_00_80_00_00, 40'h01_00_40_00_00, 40'h01_00_20_00_00, 40'h01_00_00_00_00,
        40'h03_12_34_00_FF, 40'h03_BF_FF_00_FF
    };

    fapcd_dispatch uut (
        .clock(clock),
        .sys_rst(sys_rst),
        .clockEn(clockEn),
        .wb_cyc_i(wbCyc),
        .wb_stb_i(wbStb),
        .wb_we_i(wbWe),
        .wb_adr_i(wbAdr),
        .wb_dat_i(wbDatW),
        .wb_sel_i(wbSel),
        .wb_dat_o(wbDatR),
        .wb_ack_o(wbAck),
        .watchdogFeed(watchdogFeed),
        .serviceBusy(serviceBusy)
    );

    fapcd_app_model app (
        .clock(clock),
        .wb_ack_i(wbAck),
        .wb_dat_i(wbDatR),
        .wb_cyc_o(wbCyc),
        .wb_stb_o(wbStb),
        .wb_we_o(wbWe),
        .wb_adr_o(wbAdr),
        .wb_dat_o(wbDatW),
        .wb_sel_o(wbSel)
    );

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    always @(posedge clock) begin
        if (watchdogFeed === 1'b1) wdCount++;
    end

    task automatic check(input logic [7:0] gotVal, input logic [7:0] expVal);
        testsRun++;
        if (gotVal !== expVal) begin
            $display("ERROR at %0t: got %h expected %h", $time, gotVal, expVal);
            badCount++;
        end
    endtask

    task automatic tallyAndFinish();
        $display("Checks run %0d, mismatches %0d", testsRun, badCount);
        if (badCount == 0 && testsRun > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // About 50 calls of at most a few hundred cycles each; the limit leaves a wide margin.
    initial begin
        repeat (40000) @(posedge clock);
        badCount++;
        $display("ERROR at %0t: cycles %h limit %h", $time, 40000, 40000);
        tallyAndFinish();
    end

    initial begin
        sys_rst = 1'b1;
        clockEn = 1'b1;
        repeat (10) @(posedge clock);
        sys_rst <= 1'b0;
        app.access(1'b1, 4'hF, 8'hA5, got);
        for (int a = 0; a < 16; a++) begin
            app.access(1'b0, 4'(a), 8'h00, got);
            check(got, 8'h00);
        end
        $display("Reset values and unmapped index done");
        for (int i = 0; i < 47; i++) begin
            {f, h, l, d, e} = rows[i];
            wdCount = 0;
            app.callService(f, h, l, d, got);
            check(got, e);
            check(8'(wdCount), {7'h00, f[7]});
        end
        $display("Table of %0d calls done", 47);
        app.access(1'b1, `FAPCD_OFF_FUNC, 8'h02, got);
        app.access(1'b1, `FAPCD_OFF_AHI, 8'h00, got);
        app.access(1'b1, `FAPCD_OFF_ALO, 8'h01, got);
        app.access(1'b1, `FAPCD_OFF_DATA, 8'h5C, got);
        app.access(1'b1, `FAPCD_OFF_ENTRY, 8'h00, got);
        got = 8'h00;
        while (got[0] !== 1'b1) app.access(1'b0, `FAPCD_OFF_STAT, 8'h00, got);
        check({7'h00, serviceBusy}, 8'h01);
        app.access(1'b1, `FAPCD_OFF_FUNC, 8'h09, got);
        got = 8'h00;
        while (got[1] !== 1'b1) app.access(1'b0, `FAPCD_OFF_STAT, 8'h00, got);
        app.access(1'b0, `FAPCD_OFF_FUNC, 8'h00, got);
        check(got, 8'h02);
        check({7'h00, serviceBusy}, 8'h00);
        app.access(1'b0, `FAPCD_OFF_DATA, 8'h00, got);
        check(got, `FAPCD_PASS);
        app.callService(8'h03, 8'h00, 8'h01, 8'h00, got);
        check(got, 8'h5C);
        app.access(1'b0, `FAPCD_OFF_CFG, 8'h00, got);
        check(got, 8'h87);
        $display("Write during busy and configuration done");
        sys_rst <= 1'b1;
        repeat (10) @(posedge clock);
        sys_rst <= 1'b0;
        app.access(1'b0, `FAPCD_OFF_CFG, 8'h00, got);
        check(got, 8'h00);
        app.callService(8'h07, 8'h00, 8'h02, 8'h00, got);
        check(got, 8'hFF);
        $display("Reset in mid-run done");
        tallyAndFinish();
    end
endmodule
